//--- rtl/dwu_pkg.sv
// Shared constants of the dual watchdog unit
package dwu_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Independent watchdog
	localparam int unsigned        IND_PRE_W         = 8;
	localparam int unsigned        IND_CNT_W         = 12;
	localparam int unsigned        IND_PSEL_W        = 3;
	localparam logic [IND_PSEL_W-1:0] IND_PSEL_MAX   = 3'h6;
	localparam logic [IND_PRE_W-1:0]  IND_PRE_BASE   = 8'h04;
	localparam logic [IND_CNT_W-1:0]  IND_RELOAD_RST = 12'hfff;
	localparam logic [IND_CNT_W-1:0]  IND_WINDOW_RST = 12'hfff;
	localparam logic [IND_CNT_W-1:0]  IND_CNT_ZERO   = 12'h000;
	localparam logic [IND_PRE_W-1:0]  IND_PRE_ZERO   = 8'h00;
	localparam logic [IND_PRE_W-1:0]  IND_PRE_ONE    = 8'h01;
	localparam logic [IND_CNT_W-1:0]  IND_CNT_ONE    = 12'h001;

	////////////////////////////////////////////////////////////////////////////////
	// Window watchdog
	localparam int unsigned        WIN_CNT_W         = 7;
	localparam int unsigned        WIN_DIV_W         = 16;
	localparam int unsigned        WIN_TB_W          = 2;
	localparam int unsigned        WIN_BASE_DIV      = 4096;
	localparam int unsigned        WIN_T6_BIT        = 6;
	localparam logic [WIN_CNT_W-1:0] WIN_CNT_RST     = 7'h7f;
	localparam logic [WIN_CNT_W-1:0] WIN_WINDOW_RST  = 7'h7f;
	localparam logic [WIN_CNT_W-1:0] WIN_EWI_VAL     = 7'h40;
	localparam logic [WIN_CNT_W-1:0] WIN_CNT_ONE     = 7'h01;
	localparam logic [WIN_DIV_W-1:0] WIN_DIV_ZERO    = 16'h0000;
	localparam logic [WIN_DIV_W-1:0] WIN_DIV_ONE     = 16'h0001;

	////////////////////////////////////////////////////////////////////////////////
	// Pin synchroniser depth plus one stage for edge detection
	localparam int unsigned        SYNC_W            = 3;

endpackage

//--- rtl/dwu_ind_watchdog.sv
// Independent watchdog: prescaler and downcounter ticked by the sampled RC clock
`timescale 1ns/1ps
module dwu_ind_watchdog
	import dwu_pkg::*;
(
	input  wire logic                  i_ref_clk,
	input  wire logic                  i_rst,
	input  wire logic                  i_tick,
	input  wire logic                  i_hw_opt,
	input  wire logic                  i_start,
	input  wire logic                  i_refresh,
	input  wire logic [IND_PSEL_W-1:0] i_prescale,
	input  wire logic [IND_CNT_W-1:0]  i_reload,
	input  wire logic [IND_CNT_W-1:0]  i_window,
	input  wire logic                  i_freeze,
	output logic [IND_CNT_W-1:0]       o_count,
	output logic                       o_running,
	output logic                       o_expire,
	output logic                       o_early
);
	import dwu_pkg::*;

	typedef struct packed {
		logic [IND_PRE_W-1:0] pre;
		logic [IND_CNT_W-1:0] cnt;
		logic                 running;
		logic                 expire;
		logic                 early;
	} dwu_ind_state_t;

	dwu_ind_state_t s;
	dwu_ind_state_t next_s;
	logic [IND_PRE_W-1:0] pre_limit;
	logic [IND_PSEL_W-1:0] psel;

	////////////////////////////////////////////////////////////////////////////////
	always_comb begin
		next_s = s;
		next_s.expire = 1'b0;
		next_s.early = 1'b0;
		// Out-of-range selections saturate at the slowest division
		psel = (i_prescale > IND_PSEL_MAX) ? IND_PSEL_MAX : i_prescale;
		// One spare bit keeps the divide-by-256 setting from wrapping to zero
		pre_limit = IND_PRE_W'(({1'b0, IND_PRE_BASE} << psel) - {1'b0, IND_PRE_ONE});
		if (!s.running) begin
			// Option strap starts it by itself; software start otherwise
			if (i_hw_opt || i_start) begin
				next_s.running = 1'b1;
				next_s.cnt = i_reload;
				next_s.pre = IND_PRE_ZERO;
			end
		end else if (i_refresh) begin
			// Refresh above the window is refused and flagged
			if (s.cnt > i_window) begin
				next_s.early = 1'b1;
			end else begin
				next_s.cnt = i_reload;
				next_s.pre = IND_PRE_ZERO;
			end
		end else if (i_tick && !i_freeze) begin
			if (s.pre >= pre_limit) begin
				next_s.pre = IND_PRE_ZERO;
				if (s.cnt == IND_CNT_ZERO) begin
					next_s.expire = 1'b1;
					next_s.cnt = i_reload;
				end else begin
					next_s.cnt = s.cnt - IND_CNT_ONE;
				end
			end else begin
				next_s.pre = s.pre + IND_PRE_ONE;
			end
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			s <= '{pre: IND_PRE_ZERO, cnt: IND_RELOAD_RST, running: 1'b0, expire: 1'b0, early: 1'b0};
		end else begin
			s <= next_s;
		end
	end

	assign o_count   = s.cnt;
	assign o_running = s.running;
	assign o_expire  = s.expire;
	assign o_early   = s.early;

endmodule // dwu_ind_watchdog

//--- rtl/dwu_top.sv
// Dual watchdog unit: independent watchdog on the RC clock and window watchdog on the bus clock
// Notes on behaviour
// - independent: 8-bit prescaler feeding 12-bit downcounter
// - independent refresh accepted only inside window
// - independent counts from separate 40 kHz RC
// - independent keeps counting in stop, standby
// - independent expiry resets device in watchdog use
// - independent usable as free-running timeout timer
// - option strap selects hardware or software start
// - each watchdog freezable during debug halt
// - window watchdog: 7-bit downcounter, may free-run
// - window watchdog resets on wrong servicing
// - window watchdog counts from peripheral bus clock
// - window watchdog early-warning interrupt before reset
`timescale 1ns/1ps
module dwu_top
	import dwu_pkg::*;
#(
	parameter int unsigned WIN_BASE_DIV_P = WIN_BASE_DIV
) (
	// Clock, reset and pins
	input  wire logic                   i_ref_clk,
	input  wire logic                   i_rst,
	input  wire logic                   i_lsi_clk,
	input  wire logic                   i_low_power,
	input  wire logic                   i_dbg_halt,
	// Independent watchdog control
	input  wire logic                   i_ind_hw_opt,
	input  wire logic                   i_ind_start,
	input  wire logic                   i_ind_refresh,
	input  wire logic [IND_PSEL_W-1:0]  i_ind_prescale,
	input  wire logic [IND_CNT_W-1:0]   i_ind_reload,
	input  wire logic [IND_CNT_W-1:0]   i_ind_window,
	input  wire logic                   i_ind_timer_mode,
	input  wire logic                   i_ind_timeout_clr,
	input  wire logic                   i_ind_dbg_freeze,
	// Window watchdog control
	input  wire logic                   i_win_write,
	input  wire logic [WIN_CNT_W-1:0]   i_win_wdata,
	input  wire logic                   i_win_activate,
	input  wire logic [WIN_CNT_W-1:0]   i_win_window,
	input  wire logic [WIN_TB_W-1:0]    i_win_tb,
	input  wire logic                   i_win_ewi_en,
	input  wire logic                   i_win_ewi_clr,
	input  wire logic                   i_win_dbg_freeze,
	// Counters, flags and reset request
	output logic [IND_CNT_W-1:0]        o_ind_count,
	output logic                        o_ind_running,
	output logic                        o_ind_timeout,
	output logic [WIN_CNT_W-1:0]        o_win_count,
	output logic                        o_win_active,
	output logic                        o_win_ewi,
	output logic                        o_sys_reset_req,
	output logic                        o_ind_reset_flag,
	output logic                        o_win_reset_flag
);
	import dwu_pkg::*;

	typedef struct packed {
		logic [SYNC_W-1:0]    lsi_sync;
		logic [WIN_DIV_W-1:0] win_pre;
		logic [WIN_CNT_W-1:0] win_cnt;
		logic                 win_active;
		logic                 win_ewi;
		logic                 ind_timeout;
		logic                 sys_rst;
		logic                 ind_rst_flag;
		logic                 win_rst_flag;
	} dwu_top_state_t;

	dwu_top_state_t s;
	dwu_top_state_t next_s;

	logic                 lsi_tick;
	logic                 ind_expire;
	logic                 ind_early;
	logic                 ind_armed;
	logic                 ind_fault;
	logic                 win_fault;
	logic                 win_hold;
	logic                 win_step;
	logic [WIN_DIV_W-1:0] win_limit;
	logic [WIN_CNT_W-1:0] win_dec;

	////////////////////////////////////////////////////////////////////////////////
	// The RC clock is foreign to i_ref_clk, so it is sampled and edge detected.
	// The 50 MHz reference oversamples 40 kHz by far, so no RC edge is lost.
	// An RC clock already high at reset release yields one early tick;
	// that shortens only the first span, by a single tick at most.
	assign lsi_tick = s.lsi_sync[1] & ~s.lsi_sync[2];

	// Debug freeze of the independent counter is gated here, next to the halt input
	dwu_ind_watchdog u_ind (
		.i_ref_clk  (i_ref_clk),
		.i_rst      (i_rst),
		.i_tick     (lsi_tick),
		.i_hw_opt   (i_ind_hw_opt),
		.i_start    (i_ind_start),
		.i_refresh  (i_ind_refresh),
		.i_prescale (i_ind_prescale),
		.i_reload   (i_ind_reload),
		.i_window   (i_ind_window),
		.i_freeze   (i_dbg_halt & i_ind_dbg_freeze),
		.o_count    (o_ind_count),
		.o_running  (o_ind_running),
		.o_expire   (ind_expire),
		.o_early    (ind_early)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Independent watchdog fault: expiry or a refused refresh, unless used as timer
	// The hardware strap forces watchdog use, so timer mode cannot disarm it
	assign ind_armed = i_ind_hw_opt | ~i_ind_timer_mode;
	assign ind_fault = (ind_expire | ind_early) & ind_armed;

	// Window watchdog prescaler runs from the bus clock; bus clock stops in low power
	// Debug freeze and low power both stop the bus-clock prescaler
	assign win_hold  = i_low_power || (i_dbg_halt && i_win_dbg_freeze);
	// Limit is cut to the prescaler width; the largest time base still fits
	assign win_limit = WIN_DIV_W'((WIN_BASE_DIV_P << i_win_tb) - 1);
	assign win_step  = (s.win_pre >= win_limit) && !win_hold;
	assign win_dec   = s.win_cnt - WIN_CNT_ONE;

	always_comb begin
		next_s = s;
		win_fault = 1'b0;
		next_s.sys_rst = 1'b0;
		next_s.lsi_sync = {s.lsi_sync[SYNC_W-2:0], i_lsi_clk};

		////////////////////////////////////////////////////////////////////////////////
		// Window watchdog counter
		// A write wins over a step in the same cycle
		if (!win_hold) begin
			next_s.win_pre = win_step ? WIN_DIV_ZERO : s.win_pre + WIN_DIV_ONE;
		end
		if (i_win_activate) begin
			next_s.win_active = 1'b1;
		end
		if (i_win_write) begin
			// A write above the window is too early; loading T6 clear trips at once
			if (s.win_active && (s.win_cnt > i_win_window)) begin
				// Refused write leaves the counter as it was
				win_fault = 1'b1;
			end else begin
				next_s.win_cnt = i_win_wdata;
				// Prescaler restarts so an accepted write gets a full step
				next_s.win_pre = WIN_DIV_ZERO;
				if ((s.win_active || i_win_activate) && !i_win_wdata[WIN_T6_BIT]) begin
					win_fault = 1'b1;
				end
			end
		end else if (win_step) begin
			// Counter free-runs even when not activated
			next_s.win_cnt = win_dec;
			if (s.win_active && (s.win_cnt == WIN_EWI_VAL)) begin
				win_fault = 1'b1;
			end
		end

		////////////////////////////////////////////////////////////////////////////////
		// Early warning flag: set wins over clear
		if (i_win_ewi_clr) begin
			next_s.win_ewi = 1'b0;
		end
		if (win_step && !i_win_write && i_win_ewi_en && (win_dec == WIN_EWI_VAL)) begin
			next_s.win_ewi = 1'b1;
		end

		////////////////////////////////////////////////////////////////////////////////
		// Timeout flag of the independent watchdog in timer use: set wins over clear
		if (i_ind_timeout_clr) begin
			next_s.ind_timeout = 1'b0;
		end
		if (ind_expire && !ind_armed) begin
			next_s.ind_timeout = 1'b1;
		end

		////////////////////////////////////////////////////////////////////////////////
		// System reset request and cause flags; flags clear only on i_rst
		// Request is one cycle wide; the reset controller must catch it on this clock
		if (ind_fault) begin
			next_s.sys_rst = 1'b1;
			next_s.ind_rst_flag = 1'b1;
		end
		if (win_fault) begin
			next_s.sys_rst = 1'b1;
			next_s.win_rst_flag = 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// State register; i_rst is synchronous to i_ref_clk
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			s <= '{
				lsi_sync:     '0,
				win_pre:      WIN_DIV_ZERO,
				win_cnt:      WIN_CNT_RST,
				win_active:   1'b0,
				win_ewi:      1'b0,
				ind_timeout:  1'b0,
				sys_rst:      1'b0,
				ind_rst_flag: 1'b0,
				win_rst_flag: 1'b0
			};
		end else begin
			s <= next_s;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	assign o_ind_timeout    = s.ind_timeout;
	assign o_win_count      = s.win_cnt;
	assign o_win_active     = s.win_active;
	assign o_win_ewi        = s.win_ewi;
	assign o_sys_reset_req  = s.sys_rst;
	assign o_ind_reset_flag = s.ind_rst_flag;
	assign o_win_reset_flag = s.win_rst_flag;

endmodule // dwu_top

//--- tb/dwu_chk_properties.sv
// Port-level checker of the dual watchdog unit
`timescale 1ns/1ps
module dwu_chk
	import dwu_pkg::*;
(
	input  wire logic                 i_ref_clk,
	input  wire logic                 i_rst,
	input  wire logic                 i_low_power,
	input  wire logic                 i_ind_refresh,
	input  wire logic [IND_CNT_W-1:0] i_ind_reload,
	input  wire logic [IND_CNT_W-1:0] i_ind_window,
	input  wire logic                 i_win_write,
	input  wire logic [WIN_CNT_W-1:0] i_win_wdata,
	input  wire logic                 i_win_activate,
	input  wire logic [WIN_CNT_W-1:0] i_win_window,
	input  wire logic [IND_CNT_W-1:0] o_ind_count,
	input  wire logic                 o_ind_running,
	input  wire logic [WIN_CNT_W-1:0] o_win_count,
	input  wire logic                 o_win_active,
	input  wire logic                 o_win_ewi,
	input  wire logic                 o_sys_reset_req,
	input  wire logic                 o_ind_reset_flag,
	input  wire logic                 o_win_reset_flag
);
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (i_rst);
	////////////////////////////////////////////////////////////
	chk_reset_values: assert property ($fell(i_rst) |-> o_ind_count == IND_RELOAD_RST && o_win_count == WIN_CNT_RST)
		else $error("counts not at reset value");
	chk_req_has_cause: assert property (o_sys_reset_req |-> o_ind_reset_flag || o_win_reset_flag)
		else $error("reset request without cause flag");
	chk_ind_flag_sticky: assert property (o_ind_reset_flag |=> o_ind_reset_flag)
		else $error("independent cause flag dropped");
	chk_win_flag_sticky: assert property (o_win_reset_flag |=> o_win_reset_flag)
		else $error("window cause flag dropped");
	chk_ind_refresh: assert property (i_ind_refresh && o_ind_running && o_ind_count <= i_ind_window
		|=> o_ind_count == $past(i_ind_reload)) else $error("refresh inside window not loaded");
	chk_win_load: assert property (i_win_write && !o_win_active && !i_win_activate
		|=> o_win_count == $past(i_win_wdata)) else $error("window counter write not loaded");
	chk_win_refused: assert property (i_win_write && o_win_active && o_win_count > i_win_window
		|=> o_sys_reset_req) else $error("early window write not faulted");
	// Bus clock is gated in low power, so the window counter must hold
	chk_win_lp_hold: assert property (i_low_power && !i_win_write |=> $stable(o_win_count))
		else $error("window counter moved in low power");
	chk_ewi_at_40: assert property ($rose(o_win_ewi) |-> o_win_count == WIN_EWI_VAL)
		else $error("early warning not at count 40");
endmodule // dwu_chk

bind dwu_top dwu_chk u_chk (
	.i_ref_clk, .i_rst, .i_low_power, .i_ind_refresh, .i_ind_reload, .i_ind_window,
	.i_win_write, .i_win_wdata, .i_win_activate, .i_win_window, .o_ind_count, .o_ind_running,
	.o_win_count, .o_win_active, .o_win_ewi, .o_sys_reset_req, .o_ind_reset_flag, .o_win_reset_flag
);

//--- tb/dwu_tb_top.sv
// Self-checking testbench of the dual watchdog unit
`timescale 1ns/1ps
module dwu_tb_top;
	import dwu_pkg::*;
	logic                 clk, rst, lsi, lp, halt, hw, st, rf, tmode, tclr, ifz;
	logic                 ww, wact, ewen, ewclr, wfz;
	logic [IND_CNT_W-1:0] rld, iwin, ic;
	logic [WIN_CNT_W-1:0] wd, wwin, wc;
	logic                 irun, itmo, wa, ewi, req, iflag, wflag;
	logic [2:0]           ipre;
	logic [1:0]           wtb;
	int                   fails, n_checks, k;
	// Divider of 4 keeps a window step at 4 clocks instead of 4096
	dwu_top #(.WIN_BASE_DIV_P(4)) u_dut (
		.i_ref_clk(clk), .i_rst(rst), .i_lsi_clk(lsi), .i_low_power(lp), .i_dbg_halt(halt),
		.i_ind_hw_opt(hw), .i_ind_start(st), .i_ind_refresh(rf), .i_ind_prescale(ipre),
		.i_ind_reload(rld), .i_ind_window(iwin), .i_ind_timer_mode(tmode), .i_ind_timeout_clr(tclr),
		.i_ind_dbg_freeze(ifz), .i_win_write(ww), .i_win_wdata(wd), .i_win_activate(wact),
		.i_win_window(wwin), .i_win_tb(wtb), .i_win_ewi_en(ewen), .i_win_ewi_clr(ewclr),
		.i_win_dbg_freeze(wfz), .o_ind_count(ic), .o_ind_running(irun), .o_ind_timeout(itmo),
		.o_win_count(wc), .o_win_active(wa), .o_win_ewi(ewi), .o_sys_reset_req(req),
		.o_ind_reset_flag(iflag), .o_win_reset_flag(wflag)
	);
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// RC clock runs free at one edge pair per 8 reference cycles
	initial begin
		lsi = 1'b0;
		forever #80 lsi = ~lsi;
	end
	////////////////////////////////////////////////////////////
	task tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task rst_dut(input int n, input logic h);
		{lp, halt, st, rf, tmode, tclr, ifz, ww, wact, ewen, ewclr, wfz} = 12'h000;
		hw = h;
		ipre = 3'h0;
		wtb = 2'h0;
		rld = 12'hfff;
		iwin = 12'hfff;
		wd = 7'h7f;
		wwin = 7'h7f;
		rst = 1'b1;
		tick(n);
		rst = 1'b0;
	endtask
	task cmp_bit(input string nm, input logic e, input logic g);
		n_checks++;
		if (g !== e) begin
			fails++;
			$display("[FAIL] %s exp %b got %b", nm, e, g);
		end
	endtask
	task cmp_val(input string nm, input logic [11:0] e, input logic [11:0] g);
		n_checks++;
		if (g !== e) begin
			fails++;
			$display("[FAIL] %s exp %h got %h", nm, e, g);
		end
	endtask
	// Bounded wait for request, timeout or early warning
	task wt(input int s, input int lim, output int n);
		n = 0;
		while ((s == 0 ? req : s == 1 ? itmo : ewi) !== 1'b1 && n < lim) begin
			tick(1);
			n++;
		end
	endtask
	task final_report();
		if (fails == 0 && n_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	////////////////////////////////////////////////////////////
	task t_ind_expire();
		rst_dut(2, 1'b0);
		lp = 1'b1;
		rld = 12'h003;
		st = 1'b1;
		tick(1);
		st = 1'b0;
		rf = 1'b1;
		tick(1);
		rf = 1'b0;
		wt(0, 300, k);
		cmp_bit("ind_span", 1'b1, k >= 96 && k <= 170);
		cmp_bit("ind_flag", 1'b1, iflag);
		cmp_val("win_frozen", {5'h00, WIN_CNT_RST}, {5'h00, wc});
	endtask
	task t_ind_timer();
		rst_dut(2, 1'b0);
		tmode = 1'b1;
		ipre = 3'h1;
		rld = 12'h001;
		st = 1'b1;
		tick(1);
		st = 1'b0;
		wt(1, 300, k);
		cmp_bit("pre_span", 1'b1, k >= 112 && k <= 140);
		cmp_bit("timeout", 1'b1, itmo);
		cmp_bit("no_reset", 1'b0, iflag);
		tclr = 1'b1;
		tick(1);
		tclr = 1'b0;
		cmp_bit("timeout_clr", 1'b0, itmo);
	endtask
	task t_ind_early();
		rst_dut(2, 1'b0);
		iwin = 12'h000;
		st = 1'b1;
		tick(1);
		st = 1'b0;
		rf = 1'b1;
		tick(1);
		rf = 1'b0;
		wt(0, 4, k);
		cmp_bit("early_fault", 1'b1, iflag);
	endtask
	task t_hw_freeze();
		rst_dut(2, 1'b1);
		halt = 1'b1;
		ifz = 1'b1;
		wfz = 1'b1;
		tick(200);
		cmp_bit("hw_started", 1'b1, irun);
		cmp_val("ind_frozen", IND_RELOAD_RST, ic);
		cmp_val("win_dbg", {5'h00, WIN_CNT_RST}, {5'h00, wc});
		halt = 1'b0;
		tick(100);
		cmp_bit("ind_counts", 1'b1, ic !== IND_RELOAD_RST);
	endtask
	task t_win_expire();
		rst_dut(2, 1'b0);
		ewen = 1'b1;
		wd = 7'h70;
		ww = 1'b1;
		tick(1);
		ww = 1'b0;
		cmp_val("win_load", 12'h070, {5'h00, wc});
		wact = 1'b1;
		tick(1);
		wact = 1'b0;
		cmp_bit("win_active", 1'b1, wa);
		wt(2, 400, k);
		cmp_val("ewi_count", {5'h00, WIN_EWI_VAL}, {5'h00, wc});
		ewclr = 1'b1;
		tick(1);
		ewclr = 1'b0;
		cmp_bit("ewi_clr", 1'b0, ewi);
		wt(0, 10, k);
		cmp_bit("win_flag", 1'b1, wflag);
		cmp_bit("ind_quiet", 1'b0, iflag);
	endtask
	task t_win_free();
		rst_dut(2, 1'b0);
		wtb = 2'h1;
		tick(600);
		cmp_bit("free_rate", 1'b1, wc >= 7'h33 && wc <= 7'h35);
		cmp_bit("free_idle", 1'b0, wa);
		cmp_bit("free_flag", 1'b0, wflag);
		cmp_bit("free_moves", 1'b1, wc !== WIN_CNT_RST);
	endtask
	task t_win_early();
		rst_dut(2, 1'b0);
		ww = 1'b1;
		tick(1);
		ww = 1'b0;
		wact = 1'b1;
		tick(1);
		wact = 1'b0;
		wwin = 7'h00;
		ww = 1'b1;
		tick(1);
		ww = 1'b0;
		wt(0, 3, k);
		cmp_bit("early_write", 1'b1, wflag);
		tick(1);
		cmp_bit("req_pulse", 1'b0, req);
	endtask
	task t_win_t6();
		rst_dut(2, 1'b0);
		wd = 7'h3f;
		wact = 1'b1;
		ww = 1'b1;
		tick(1);
		{ww, wact} = 2'h0;
		wt(0, 3, k);
		cmp_bit("t6_clear", 1'b1, wflag);
		cmp_bit("t6_active", 1'b1, wa);
	endtask
	////////////////////////////////////////////////////////////
	initial begin
		fails = 0;
		n_checks = 0;
		rst_dut(16, 1'b0);
		cmp_bit("run_rst", 1'b0, irun);
		cmp_val("ind_rst", IND_RELOAD_RST, ic);
		t_ind_expire();
		t_ind_timer();
		t_ind_early();
		t_hw_freeze();
		t_win_expire();
		t_win_free();
		t_win_early();
		t_win_t6();
		final_report();
	end
	initial begin
		#100us;
		fails++;
		final_report();
	end
endmodule // dwu_tb_top
